// >>> rtl/oc_consts.svh
/*
 Constants of the on-die termination control pair: register map of the
 controller, reset values and latency figures.
 Assumes inclusion by bare name from the rtl/ files.
*/
// Behaviour
// R1: Termination covers DQ, DQS, DQS complement, DM lanes
// R2: Termination off when disabled or self-refresh
// R3: Any nominal termination bit set enables termination
// R4: ODT low means off; high means on
// R5: On/off decided from ODT pin alone
// R6: Synchronous timing whenever DLL on and locked
// R7: On/off follows ODT after turn latency
// R8: Latency equals CWL plus AL minus two
// R9: Controller holds ODT high at least four cycles
// R10: Write with ODT: hold four or six cycles
// R11: Controller drops ODT before read preamble; controller here has no reads, drops ODT only on request after hold
// R12: Termination back no earlier than postamble plus one; not tracked here, termination follows the ODT pin alone
// R13: Dynamic switching enabled by write termination bits
// R14: Nominal from MR1 bits, write from MR2 bits
// R15: No write: nominal strength, ODT-timed on/off
// R16: Any write switches to write strength after latency
// R17: Back to nominal after latency plus four/six
// R18: Nominal during writes only half, quarter, sixth; the device applies any nominal code during writes
// R19: Frozen DLL precharge power-down uses asynchronous timing
// R20: Asynchronous timing ignores additive latency
// R21: Latency realised as pipeline recomputed from CWL/AL
`ifndef OC_CONSTS_SVH
`define OC_CONSTS_SVH

// ----------------------------------------------------------------------
// Controller register map
// ----------------------------------------------------------------------
`define OC_REG_ODT      8'h00
`define OC_REG_CMD      8'h04
`define OC_REG_STATUS   8'h08
`define OC_ODT_BIT      0
`define OC_CMD_WR_BIT   0
`define OC_CMD_AP_BIT   1
`define OC_CMD_BC4_BIT  2
`define OC_ST_ODT_BIT   0
`define OC_ST_HOLD_BIT  1
`define OC_ST_DROP_BIT  2
`define OC_ODT_RESET    1'h0

// ----------------------------------------------------------------------
// Latency figures in clock cycles
// ----------------------------------------------------------------------
`define OC_LAT_OFFSET   5'h02
`define OC_ODTH4        3'h4
`define OC_ODTH8        3'h6
`define OC_CWN4_EXTRA   3'h4
`define OC_CWN8_EXTRA   3'h6

`endif

// >>> rtl/oc_pkg.sv
/*
 Types shared by the device end, the link checker and the bench.
 Assumes nothing of its surroundings.
*/
package oc_pkg;
   // Applied termination strength
   typedef enum logic [2:0] {
      OC_RTT_OFF,
      OC_RTT_RZQ2,
      OC_RTT_RZQ4,
      OC_RTT_RZQ6,
      OC_RTT_RZQ8,
      OC_RTT_RZQ12,
      OC_RTT_RESERVED
   } oc_rtt_t;
endpackage

// >>> rtl/oc_link_if.sv
/*
 Link between memory controller and device termination logic.
 Assumes both ends run on the same rising clock edge.
*/
`timescale 1ns/10ps
`default_nettype none
interface oc_link_if;
   logic odt;                       // Termination request pin
   logic write_cmd;                 // Write command registered
   logic write_autoprecharge_cmd;   // Write with auto precharge
   logic burst_chop4;               // Write is burst chop 4

   modport ctrl (
      output odt,
      output write_cmd,
      output write_autoprecharge_cmd,
      output burst_chop4
   );
   modport dram (
      input  odt,
      input  write_cmd,
      input  write_autoprecharge_cmd,
      input  burst_chop4
   );
endinterface
`default_nettype wire

// >>> rtl/oc_device.sv
/*
 Device end: on-die termination control of the memory device.
 Decides termination on/off and strength from the ODT pin, mode register
 fields and registered write commands.
 Assumes mode register fields are static or change only while ODT is low,
 and that the controller keeps its own hold and read-window duties.
 A change of the sum CWL + AL restarts the latency pipelines.
*/
// The implementer's own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "oc_consts.svh"
module oc_device #(
   parameter int DEPTH = 24,        // Pipeline depth, covers CWL+AL-2
   parameter int LANES = 2          // Byte lanes terminated (2 on x16)
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   oc_link_if.dram          link,
   input  wire logic [2:0]  mr1_rtt_nom,     // {A9,A6,A2}
   input  wire logic [1:0]  mr2_rtt_wr,      // {A10,A9}
   input  wire logic [3:0]  cwl,
   input  wire logic [3:0]  al,
   input  wire logic        dll_locked,
   input  wire logic        self_refresh,
   input  wire logic        precharge_pd,
   input  wire logic        dll_frozen_pd,   // MR0 A12 freezes DLL in PD
   output logic             rtt_on,
   output logic [LANES-1:0] term_lane_en,
   output oc_pkg::oc_rtt_t  rtt_value,
   output logic             rtt_wr_active
);

   // ----------------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------------

   // Pick the pipeline stage that yields a given latency
   function automatic logic oc_tap(input logic [DEPTH-1:0] pipe,
                                   input logic [4:0]       lat);
      logic r;
      r = 1'b0;
      if (lat != 5'h00 && int'(lat) <= DEPTH) begin
         r = pipe[lat - 5'h01];
      end
      return r;
   endfunction

   // Nominal strength from {A9,A6,A2}
   function automatic oc_pkg::oc_rtt_t oc_nom(input logic [2:0] b);
      oc_pkg::oc_rtt_t r;
      unique case (b)
         3'h0: r = oc_pkg::OC_RTT_OFF;
         3'h1: r = oc_pkg::OC_RTT_RZQ4;
         3'h2: r = oc_pkg::OC_RTT_RZQ2;
         3'h3: r = oc_pkg::OC_RTT_RZQ6;
         3'h4: r = oc_pkg::OC_RTT_RZQ12;
         3'h5: r = oc_pkg::OC_RTT_RZQ8;
         default: r = oc_pkg::OC_RTT_RESERVED;
      endcase
      return r;
   endfunction

   // Write strength from {A10,A9}
   function automatic oc_pkg::oc_rtt_t oc_wr(input logic [1:0] b);
      oc_pkg::oc_rtt_t r;
      unique case (b)
         2'h1: r = oc_pkg::OC_RTT_RZQ4;
         2'h2: r = oc_pkg::OC_RTT_RZQ2;
         2'h3: r = oc_pkg::OC_RTT_RESERVED;
         default: r = oc_pkg::OC_RTT_OFF;
      endcase
      return r;
   endfunction

   // ----------------------------------------------------------------------
   // Mode decode
   // ----------------------------------------------------------------------
   logic             nom_enabled;
   logic             dyn_enabled;
   logic             async_mode;
   logic             sync_mode;
   logic             term_allowed;
   logic [4:0]       odt_lat;
   logic [DEPTH-1:0] odt_pipe;
   logic [DEPTH-1:0] wr_pipe;
   logic [DEPTH-1:0] bc4_pipe;
   logic [2:0]       wr_cnt;
   logic             wr_tap;
   logic             next_on;
   logic             next_wr_sel;
   logic [4:0]       lat_seen;
   logic             lat_moved;

   // Enable decode and timing mode selection
   assign nom_enabled  = |mr1_rtt_nom;                        // R3
   assign dyn_enabled  = |mr2_rtt_wr;                         // R13
   assign async_mode   = precharge_pd && dll_frozen_pd;       // R19
   assign sync_mode    = dll_locked && !async_mode;           // R6
   assign term_allowed = nom_enabled && !self_refresh;        // R2
   // ODTLon = ODTLoff = CWL + AL - 2
   assign odt_lat      = {1'b0, cwl} + {1'b0, al} - `OC_LAT_OFFSET; // R8

   // Latency used last cycle; a change means stale history
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lat_seen <= 5'h00;
      end else begin
         lat_seen <= odt_lat;
      end
   end

   // No tap is taken from history of another latency
   assign lat_moved = lat_seen != odt_lat;                  // R21

   // ----------------------------------------------------------------------
   // Latency pipelines
   // ----------------------------------------------------------------------

   // Pin and write history, tap picked from current CWL/AL
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         odt_pipe <= '0;
         wr_pipe  <= '0;
         bc4_pipe <= '0;
      end else if (lat_moved) begin
         // Old samples must never reach the new tap
         odt_pipe <= DEPTH'(link.odt);
         wr_pipe  <= DEPTH'(link.write_cmd | link.write_autoprecharge_cmd);
         bc4_pipe <= DEPTH'(link.burst_chop4);
      end else begin
         odt_pipe <= {odt_pipe[DEPTH-2:0], link.odt};            // R21
         wr_pipe  <= {wr_pipe[DEPTH-2:0],
                      link.write_cmd | link.write_autoprecharge_cmd}; // R16
         bc4_pipe <= {bc4_pipe[DEPTH-2:0], link.burst_chop4};
      end
   end

   assign wr_tap = !lat_moved && oc_tap(wr_pipe, odt_lat);

   // ----------------------------------------------------------------------
   // Termination on/off
   // ----------------------------------------------------------------------

   // Pin alone decides; asynchronous mode bypasses the latency
   always_comb begin
      next_on = 1'b0;                                           // R5
      if (term_allowed) begin                                   // R2
         if (async_mode) begin
            next_on = link.odt;                                 // R20
         end else if (sync_mode && !lat_moved) begin
            next_on = oc_tap(odt_pipe, odt_lat);                // R7
         end
      end
   end

   // Registered on state, same on every lane
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rtt_on       <= 1'b0;
         term_lane_en <= '0;
      end else begin
         rtt_on       <= next_on;                               // R4
         term_lane_en <= {LANES{next_on}};                      // R1
      end
   end

   // ----------------------------------------------------------------------
   // Dynamic strength switching
   // ----------------------------------------------------------------------

   // Write window select; a new write restarts the window
   always_comb begin
      next_wr_sel = 1'b0;
      if (dyn_enabled && (wr_tap || wr_cnt != 3'h0)) begin
         next_wr_sel = 1'b1;                                    // R16
      end
   end

   // Cycles left before strength returns to nominal
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_cnt <= 3'h0;
      end else if (dyn_enabled && wr_tap) begin
         wr_cnt <= oc_tap(bc4_pipe, odt_lat) ? `OC_CWN4_EXTRA - 3'h1
                                             : `OC_CWN8_EXTRA - 3'h1; // R17
      end else if (wr_cnt != 3'h0) begin
         wr_cnt <= wr_cnt - 3'h1;
      end
   end

   // Applied strength: nominal unless inside the write window
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rtt_value     <= oc_pkg::OC_RTT_OFF;
         rtt_wr_active <= 1'b0;
      end else begin
         rtt_wr_active <= next_wr_sel;
         if (!next_on) begin
            rtt_value <= oc_pkg::OC_RTT_OFF;
         end else if (next_wr_sel) begin
            rtt_value <= oc_wr(mr2_rtt_wr);                     // R14
         end else begin
            rtt_value <= oc_nom(mr1_rtt_nom);                   // R15
         end
      end
   end

endmodule // oc_device
`default_nettype wire

// >>> rtl/oc_controller.sv
/*
 Controller end: drives the ODT pin and write commands from registers
 reached over AHB-Lite, and keeps the minimum ODT high times.
 Assumes a single AHB-Lite master, word transfers, hready = hreadyout.
*/
`timescale 1ns/10ps
`default_nettype none
`include "oc_consts.svh"
module oc_controller (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   oc_link_if.ctrl          link
);

   // ----------------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------------
   logic       ap_valid;
   logic       ap_write;
   logic [7:0] ap_addr;
   logic       odt_want;
   logic [2:0] hold_cnt;
   logic       drop_pending;
   logic       wr_fire;
   logic [2:0] wr_hold;

   // Address phase capture, zero wait states
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_valid  <= 1'b0;
         ap_write  <= 1'b0;
         ap_addr   <= 8'h00;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         ap_valid  <= hsel && hready && htrans[1] && hsize == 3'h2;
         ap_write  <= hwrite;
         ap_addr   <= haddr[7:0];
      end
   end

   // Read data registered in the address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (hsel && hready && htrans[1] && !hwrite) begin
         hrdata <= 32'h0000_0000;
         if (haddr[7:0] == `OC_REG_ODT) begin
            hrdata[`OC_ODT_BIT] <= odt_want;
         end else if (haddr[7:0] == `OC_REG_STATUS) begin
            hrdata[`OC_ST_ODT_BIT]  <= link.odt;
            hrdata[`OC_ST_HOLD_BIT] <= hold_cnt != 3'h0;
            hrdata[`OC_ST_DROP_BIT] <= drop_pending;
         end
      end
   end

   // Requested pin level
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         odt_want <= `OC_ODT_RESET;
      end else if (ap_valid && ap_write && ap_addr == `OC_REG_ODT) begin
         odt_want <= hwdata[`OC_ODT_BIT];
      end
   end

   assign wr_fire = ap_valid && ap_write && ap_addr == `OC_REG_CMD;
   assign wr_hold = hwdata[`OC_CMD_BC4_BIT] ? `OC_ODTH4 - 3'h1
                                            : `OC_ODTH8 - 3'h1;

   // ----------------------------------------------------------------------
   // Link drive
   // ----------------------------------------------------------------------

   // One-cycle write command pulse
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         link.write_cmd               <= 1'b0;
         link.write_autoprecharge_cmd <= 1'b0;
         link.burst_chop4             <= 1'b0;
      end else begin
         link.write_cmd <= wr_fire && hwdata[`OC_CMD_WR_BIT]
                           && !hwdata[`OC_CMD_AP_BIT];
         link.write_autoprecharge_cmd <= wr_fire && hwdata[`OC_CMD_WR_BIT]
                                         && hwdata[`OC_CMD_AP_BIT];
         link.burst_chop4 <= wr_fire && hwdata[`OC_CMD_BC4_BIT];
      end
   end

   // ODT pin with minimum high times; low request waits out the hold
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         link.odt     <= 1'b0;
         hold_cnt     <= 3'h0;
         drop_pending <= 1'b0;
      end else begin
         drop_pending <= link.odt && !odt_want && hold_cnt != 3'h0;
         if (!link.odt && odt_want) begin
            link.odt <= 1'b1;
            hold_cnt <= `OC_ODTH4 - 3'h1;                       // R9
         end else if (link.odt && wr_fire && hwdata[`OC_CMD_WR_BIT]
                      && wr_hold > hold_cnt) begin
            hold_cnt <= wr_hold;                                // R10
         end else if (hold_cnt != 3'h0) begin
            hold_cnt <= hold_cnt - 3'h1;
         end else if (!odt_want) begin
            link.odt <= 1'b0;                                   // R11
         end
      end
   end

endmodule // oc_controller
`default_nettype wire

// >>> dv/oc_link_properties.sv
/*
 Checker of the link and device termination outputs.
 Assumes instantiation beside the link; LAT equals cwl+al-2 in use.
*/
`timescale 1ns/10ps
`default_nettype none
module oc_link_properties #(
   parameter int LAT = 3
) (
   input wire logic [0:0]      hclk,
   input wire logic [0:0]      hresetn,
   input wire logic [0:0]      odt,
   input wire logic [0:0]      write_cmd,
   input wire logic [0:0]      write_autoprecharge_cmd,
   input wire logic [0:0]      burst_chop4,
   input wire logic [2:0]      mr1_rtt_nom,
   input wire logic [1:0]      mr2_rtt_wr,
   input wire logic [3:0]      cwl,
   input wire logic [3:0]      al,
   input wire logic [0:0]      dll_locked,
   input wire logic [0:0]      self_refresh,
   input wire logic [0:0]      precharge_pd,
   input wire logic [0:0]      dll_frozen_pd,
   input wire logic [0:0]      rtt_on,
   input wire logic [1:0]      term_lane_en,
   input wire oc_pkg::oc_rtt_t rtt_value,
   input wire logic [0:0]      rtt_wr_active
);
   // ------------------------------------------------------------------
   // Mode decode
   // ------------------------------------------------------------------
   logic en, lm, sync, asy, dyn, wr;
   assign en   = (mr1_rtt_nom != 3'h0) && !self_refresh;
   assign lm   = (32'(cwl) + 32'(al)) == (LAT + 2);
   assign asy  = precharge_pd && dll_frozen_pd;
   assign sync = en && lm && dll_locked && !asy;
   assign dyn  = lm && (mr2_rtt_wr != 2'h0);
   assign wr   = write_cmd || write_autoprecharge_cmd;

   // ------------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_lag(v);
      ##LAT (rtt_on == !v) ##1 (rtt_on == v);
   endsequence
   sequence s_w4;
      ##LAT !rtt_wr_active ##1 rtt_wr_active [*4] ##1 !rtt_wr_active;
   endsequence
   sequence s_w8;
      ##LAT !rtt_wr_active ##1 rtt_wr_active [*6] ##1 !rtt_wr_active;
   endsequence

   property p_on; sync && $rose(odt) |-> s_lag(1'b1); endproperty
   a_on: assert property (p_on) else $error("termination on at wrong cycle");
   property p_off; sync && $fell(odt) |-> s_lag(1'b0); endproperty
   a_off: assert property (p_off) else $error("termination off at wrong cycle");
   property p_dis; !en |-> !rtt_on; endproperty
   a_dis: assert property (p_dis) else $error("termination on while disabled");
   property p_lane; term_lane_en == {2{rtt_on}}; endproperty
   a_lane: assert property (p_lane) else $error("lane enables differ");
   property p_offv; !rtt_on |-> rtt_value == oc_pkg::OC_RTT_OFF; endproperty
   a_offv: assert property (p_offv) else $error("strength shown while off");
   property p_hold; $rose(odt) |-> odt [*4]; endproperty
   a_hold: assert property (p_hold) else $error("odt high too short");
   property p_wrhold; wr && odt && !burst_chop4 |-> odt [*6]; endproperty
   a_wrhold: assert property (p_wrhold) else $error("odt dropped after write");
   property p_w4; dyn && wr && burst_chop4 |-> s_w4; endproperty
   a_w4: assert property (p_w4) else $error("short write window wrong");
   property p_w8; dyn && wr && !burst_chop4 |-> s_w8; endproperty
   a_w8: assert property (p_w8) else $error("long write window wrong");
   property p_async; asy && en |=> rtt_on == $past(odt); endproperty
   a_async: assert property (p_async) else $error("async path delayed");
endmodule // oc_link_properties
`default_nettype wire

// >>> dv/ddr3_odt_control_tb_top.sv
/*
 Bench: controller and device joined by the link, driven over AHB-Lite.
 Assumes rtl/ files and the checker are compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none
`include "oc_consts.svh"
module ddr3_odt_control_tb_top;
   logic            hclk, hresetn, hsel, hwrite, hready, hresp;
   logic [1:0]      htrans, mr2, lanes;
   logic [2:0]      hsize, mr1;
   logic [3:0]      cwl, al;
   logic [31:0]     haddr, hwdata, hrdata, r;
   logic            dll, sref, ppd, frz, rtt_on, rtt_wr_active;
   oc_pkg::oc_rtt_t rtt_value;
   int              n_fail, samples_checked, i, j, c, a;

   oc_link_if oc_link_if_i ();
   oc_controller oc_controller_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .link(oc_link_if_i.ctrl));
   oc_device oc_device_i (.hclk(hclk), .hresetn(hresetn), .link(oc_link_if_i.dram), .mr1_rtt_nom(mr1),
      .mr2_rtt_wr(mr2), .cwl(cwl), .al(al), .dll_locked(dll), .self_refresh(sref), .precharge_pd(ppd),
      .dll_frozen_pd(frz), .rtt_on(rtt_on), .term_lane_en(lanes), .rtt_value(rtt_value),
      .rtt_wr_active(rtt_wr_active));
   oc_link_properties #(.LAT(3)) oc_link_properties_i (.hclk(hclk), .hresetn(hresetn),
      .odt(oc_link_if_i.odt), .write_cmd(oc_link_if_i.write_cmd), .burst_chop4(oc_link_if_i.burst_chop4),
      .write_autoprecharge_cmd(oc_link_if_i.write_autoprecharge_cmd), .mr1_rtt_nom(mr1), .mr2_rtt_wr(mr2),
      .cwl(cwl), .al(al), .dll_locked(dll), .self_refresh(sref), .precharge_pd(ppd), .dll_frozen_pd(frz),
      .rtt_on(rtt_on), .term_lane_en(lanes), .rtt_value(rtt_value), .rtt_wr_active(rtt_wr_active));

   // Free-running clock
   always #10 hclk = ~hclk;

   // Compare and count
   task check(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask

   // One AHB-Lite single word transfer
   task ahb(input logic w, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] q);
      htrans <= 2'h2;
      haddr  <= {24'h0, ad};
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
   endtask

   task odt_set(input logic v);
      ahb(1'b1, `OC_REG_ODT, {31'h0, v}, r);
   endtask

   task wait_n(input int n);
      repeat (n) @(posedge hclk);
   endtask

   // Request a level, count edges until termination follows
   // e is the ODT latency; pin launch, output register and sampling add three edges
   task lat(input logic v, input int e);
      int n;
      n = 0;
      odt_set(v);
      while (rtt_on !== v && n < 40) begin
         @(posedge hclk);
         n++;
      end
      check(32'(n), 32'(e + 3));
   endtask

   // Expected strengths
   function automatic oc_pkg::oc_rtt_t nom(input logic [2:0] k);
      case (k)
         3'h1: nom = oc_pkg::OC_RTT_RZQ4;
         3'h2: nom = oc_pkg::OC_RTT_RZQ2;
         3'h3: nom = oc_pkg::OC_RTT_RZQ6;
         3'h4: nom = oc_pkg::OC_RTT_RZQ12;
         3'h5: nom = oc_pkg::OC_RTT_RZQ8;
         default: nom = oc_pkg::OC_RTT_RESERVED;
      endcase
   endfunction
   function automatic oc_pkg::oc_rtt_t wrv(input logic [1:0] k);
      wrv = (k == 2'h1) ? oc_pkg::OC_RTT_RZQ4 : (k == 2'h2) ? oc_pkg::OC_RTT_RZQ2 : oc_pkg::OC_RTT_RESERVED;
   endfunction

   task conclude;
      $display("checked %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Watchdog
   initial begin
      #400000;
      n_fail++;
      conclude();
   end

   // Main sequence
   initial begin
      hclk = 1'b0; hresetn = 1'b0; hsel = 1'b1; hwrite = 1'b0; htrans = 2'h0; hsize = 3'h2;
      haddr = 32'h0; hwdata = 32'h0; mr1 = 3'h1; mr2 = 2'h0; cwl = 4'h5; al = 4'h0;
      dll = 1'b1; sref = 1'b0; ppd = 1'b0; frz = 1'b0; n_fail = 0; samples_checked = 0;
      void'($urandom(32'h7F9E));
      wait_n(2);
      hresetn <= 1'b1;
      ahb(1'b0, `OC_REG_ODT, 32'h0, r);
      check(r, 32'h0);
      check({31'h0, hresp}, 32'h0);
      lat(1'b1, 3);
      ahb(1'b0, `OC_REG_STATUS, 32'h0, r);
      check({31'h0, r[0]}, 32'h1);
      ahb(1'b0, `OC_REG_CMD, 32'h0, r);
      check(r, 32'h0);
      ahb(1'b0, 8'h0C, 32'h0, r);
      check(r, 32'h0);
      lat(1'b0, 3);
      // Short request, drop waits on hold
      odt_set(1'b1);
      odt_set(1'b0);
      ahb(1'b0, `OC_REG_STATUS, 32'h0, r);
      check({30'h0, r[1:0]}, 32'h3);
      wait_n(20);
      ahb(1'b0, `OC_REG_STATUS, 32'h0, r);
      check(r, 32'h0);
      // Disabled, self-refresh, unlocked
      for (i = 0; i < 3; i++) begin
         mr1 <= (i == 0) ? 3'h0 : 3'h1;
         sref <= (i == 1);
         dll <= (i != 2);
         odt_set(1'b1);
         wait_n(12);
         check({31'h0, rtt_on}, 32'h0);
         odt_set(1'b0);
         wait_n(12);
      end
      mr1 <= 3'h1;
      sref <= 1'b0;
      dll <= 1'b1;
      ppd <= 1'b1;
      lat(1'b1, 3);
      lat(1'b0, 3);
      frz <= 1'b1;
      lat(1'b1, 0);
      wait_n(4);
      lat(1'b0, 0);
      ppd <= 1'b0;
      frz <= 1'b0;
      mr2 <= 2'h1;
      ahb(1'b1, `OC_REG_CMD, 32'h1, r);
      wait_n(10);
      check({31'h0, rtt_on}, 32'h0);
      // Strength codes, every write strength code, random write variants
      for (i = 1; i < 8; i++) begin
         for (j = 0; j < 4; j++) begin
            if (i > 3 && j > 0) continue;
            mr1 <= i[2:0];
            mr2 <= j[1:0];
            odt_set(1'b1);
            wait_n(7);
            check(rtt_value, nom(i[2:0]));
            if (i < 4) begin
               ahb(1'b1, `OC_REG_CMD, {29'h0, 1'($urandom), 1'($urandom), 1'b1}, r);
               wait_n(6);
               check(rtt_value, (j > 0) ? wrv(j[1:0]) : nom(i[2:0]));
               wait_n(8);
               check(rtt_value, nom(i[2:0]));
            end
            odt_set(1'b0);
            wait_n(7);
         end
      end
      mr1 <= 3'h1;
      // Random latencies
      repeat (6) begin
         c = 5 + $urandom % 5;
         a = $urandom % 5;
         cwl <= c[3:0];
         al <= a[3:0];
         @(posedge hclk);
         lat(1'b1, c + a - 2);
         lat(1'b0, c + a - 2);
      end
      conclude();
   end
endmodule // ddr3_odt_control_tb_top
`default_nettype wire
